// [design/dcc_top.sv]
// debug counter control and data compare extension registers
`include "dcc_consts.svh"

// Overview of operation
// R1 - counter 2 counts enabled compare events
// R2 - enabled events start counter 1
// R3 - counter 2 reaching zero starts counter 1
// R4 - config clear: two independent counters
// R5 - config set: one 32-bit counter, counter-1 enables
// R6 - read/write-only compare setup limits counted accesses
// R7 - register writes may still raise counter events
// R8 - old value one posts event after load
// R9 - freshly written counter not decremented
// R10 - disabling write may still post event
// R11 - software changes counters only when safe
// R12 - value compare invert bits select not-equal
// R13 - comparator 1 mask field, reserved codes ignored
// R14 - comparator 2 mask field, same encoding
// R15 - masks only in exact mode, up to 4K
// R16 - extension cleared by power-on, or reset unowned
// R17 - owned reset clears software-owned resources only
// R18 - trigger freezes counter 1 until event
// R19 - control register resets zero, is readable
// R20 - enabled counter decrements, signals at zero
module dcc_top (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic porRst_n,
   input wire logic ext_owner_flag,
   input wire logic [1:0] resource_owner_select,
   input wire logic sprWrite,
   input wire logic [9:0] sprNum,
   input wire logic [31:0] sprWrData,
   input wire logic [12:0] ctr1EnLow,
   input wire logic [31:0] ctrLoadValue,
   input wire logic ctrLoad,
   input wire logic ext_dbg_event1,
   input wire logic ext_dbg_event2,
   input wire logic instr_complete_evt,
   input wire logic msr_dbg_allow,
   input wire logic [3:0] instr_addr_match,
   input wire logic dataAccess,
   input wire logic dataIsWrite,
   input wire logic [1:0] dataRdWrSelect1,
   input wire logic [1:0] dataRdWrSelect2,
   input wire logic [31:0] dataAddr,
   input wire logic [31:0] cmp1Addr,
   input wire logic [31:0] cmp2Addr,
   input wire logic [1:0] data_cmp_pair_mode,
   input wire logic valueEq1,
   input wire logic valueEq2,
   input wire logic trigClear,
   output logic [31:0] sprRdData,
   output logic [31:0] debug_counter_value,
   output logic ctr1_zero_evt,
   output logic ctr2_zero_evt,
   output logic ctr1_triggered_flag,
   output logic [1:0] data_value_match
);
   //****************************************
   // registers
   //****************************************
   logic [31:0] ctrlReg_r;
   logic [31:0] extReg_r;
   logic [31:0] count_r;
   dcc_pkg::dcc_trig_state_t trigState_r;
   logic [1:0] dataRdHit;
   logic [1:0] dataWrHit;
   logic [12:0] evtVec;
   logic [12:0] c1Hits;
   logic [10:0] c2Hits;
   logic c1Evt;
   logic c2Evt;
   logic trigEvt;
   logic anyTrig;
   logic c1Run;
   logic wrCtrl;
   logic wrExt;
   logic wrCnt;
   logic wrSprCnt;
   logic c1Gate;
   logic [31:0] count_nxt;
   logic z1;
   logic z2;
   logic z32;
   logic trigFire;
   dcc_match_if mIf ();

   function automatic logic dir_ok(input logic [1:0] sel, input logic isWr);
      // 01 reads only, 10 writes only, else both
      return (sel == 2'b01) ? !isWr : ((sel == 2'b10) ? isWr : 1'b1);
   endfunction

   // counters hold at zero instead of wrapping
   function automatic logic [15:0] dec_sat16(input logic [15:0] v);
      return (v == 16'h0000) ? v : v - 16'h0001;
   endfunction

   //****************************************
   // data compare helper
   //****************************************
   assign mIf.addr = dataAddr;
   assign mIf.cmp1Addr = cmp1Addr;
   assign mIf.cmp2Addr = cmp2Addr;
   assign mIf.mask1 = extReg_r[`DCC_XM1_LO +: 4];
   assign mIf.mask2 = extReg_r[`DCC_XM2_LO +: 4];
   assign mIf.pairMode = data_cmp_pair_mode;
   assign mIf.valueEq1 = valueEq1;
   assign mIf.valueEq2 = valueEq2;
   assign mIf.inv1 = extReg_r[`DCC_BIT_VC1_INV];
   assign mIf.inv2 = extReg_r[`DCC_BIT_VC2_INV];
   dcc_data_cmp uCmp (
      .m(mIf.cmp)
   );

   //****************************************
   // event sources
   //****************************************
   always_comb begin
      dataRdHit[0] = dataAccess && mIf.addrHit1 && !dataIsWrite
         && dir_ok(dataRdWrSelect1, dataIsWrite); // R6
      dataWrHit[0] = dataAccess && mIf.addrHit1 && dataIsWrite
         && dir_ok(dataRdWrSelect1, dataIsWrite); // R6
      dataRdHit[1] = dataAccess && mIf.addrHit2 && !dataIsWrite
         && dir_ok(dataRdWrSelect2, dataIsWrite); // R6
      dataWrHit[1] = dataAccess && mIf.addrHit2 && dataIsWrite
         && dir_ok(dataRdWrSelect2, dataIsWrite); // R6
   end

   // event order matches counter-1 enable bits 0..12 (irpt/ret unused here)
   assign evtVec = {2'b00, dataWrHit[1], dataRdHit[1], dataWrHit[0], dataRdHit[0],
      instr_addr_match, instr_complete_evt && msr_dbg_allow, ext_dbg_event2, ext_dbg_event1};
   assign c1Hits = evtVec & ctr1EnLow;
   assign c2Hits = evtVec[10:0] & ctrlReg_r[`DCC_BIT_C2_FIRST +: 11]; // R1
   assign c1Evt = |c1Hits; // R20
   assign c2Evt = |c2Hits && !ctrlReg_r[`DCC_BIT_CONFIG]; // R5

   assign anyTrig = |ctrlReg_r[`DCC_BIT_C2_TRIG:`DCC_BIT_TRIG_LO];
   assign z2 = (count_r[31:16] == 16'h0001) && c2Evt;
   assign trigEvt = |({dataWrHit[0], dataRdHit[0], instr_addr_match[2], instr_addr_match[0],
      ext_dbg_event2, ext_dbg_event1} & ctrlReg_r[`DCC_BIT_TRIG_HI:`DCC_BIT_TRIG_LO]) // R2
      || (ctrlReg_r[`DCC_BIT_C2_TRIG] && z2); // R3
   assign c1Run = !anyTrig || (trigState_r == dcc_pkg::DCC_RUN); // R18
   assign trigFire = anyTrig && (trigState_r == dcc_pkg::DCC_ARMED) && trigEvt;

   assign wrCtrl = sprWrite && (sprNum == `DCC_SPR_CTR_CTRL);
   assign wrExt = sprWrite && (sprNum == `DCC_SPR_CMP_EXT);
   assign wrSprCnt = sprWrite && (sprNum == `DCC_SPR_CTR_VALUE);
   assign wrCnt = wrSprCnt || ctrLoad;

   //****************************************
   // counter-1 gate
   //****************************************
   // a trigger lets its own event count
   assign c1Gate = (c1Run || trigFire) && c1Evt; // R18

   // zero detection uses the old value even during a write
   assign z1 = c1Gate && !ctrlReg_r[`DCC_BIT_CONFIG]
      && (count_r[15:0] == 16'h0001); // R7 R8 R10
   assign z32 = c1Gate && ctrlReg_r[`DCC_BIT_CONFIG]
      && (count_r == 32'h0000_0001); // R5

   //****************************************
   // counter
   //****************************************
   always_comb begin
      count_nxt = count_r;
      if (ctrlReg_r[`DCC_BIT_CONFIG]) begin
         if (c1Gate && count_r != 32'h0000_0000) begin
            count_nxt = count_r - 32'h0000_0001; // R5
         end
      end else begin
         if (c1Gate) begin
            count_nxt[15:0] = dec_sat16(count_r[15:0]); // R4 R20
         end
         if (c2Evt) begin
            count_nxt[31:16] = dec_sat16(count_r[31:16]); // R1 R4
         end
      end
   end

   // a written value replaces the decrement of the same edge
   always_ff @(posedge sys_clk) begin
      if (!porRst_n || !rst_n) begin
         count_r <= 32'h0000_0000;
      end else if (wrCnt) begin
         count_r <= wrSprCnt ? sprWrData : ctrLoadValue; // R9
      end else begin
         count_r <= count_nxt;
      end
   end

   //****************************************
   // control registers and owned reset
   //****************************************
   always_ff @(posedge sys_clk) begin
      if (!porRst_n) begin
         ctrlReg_r <= `DCC_CTR_CTRL_RESET; // R19
      end else if (!rst_n && (!ext_owner_flag
            || resource_owner_select[`DCC_OWN_CTR_CTRL])) begin
         ctrlReg_r <= `DCC_CTR_CTRL_RESET; // R17 R19
      end else if (rst_n && wrCtrl) begin
         ctrlReg_r <= sprWrData; // R10
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!porRst_n) begin
         extReg_r <= `DCC_CMP_EXT_RESET; // R16
      end else if (!rst_n && (!ext_owner_flag
            || resource_owner_select[`DCC_OWN_CMP_EXT])) begin
         extReg_r <= `DCC_CMP_EXT_RESET; // R16 R17
      end else if (rst_n && wrExt) begin
         extReg_r <= sprWrData & `DCC_CMP_EXT_MASK;
      end
   end

   //****************************************
   // trigger state
   //****************************************
   always_ff @(posedge sys_clk) begin
      if (!porRst_n || !rst_n) begin
         trigState_r <= dcc_pkg::DCC_IDLE;
      end else begin
         unique case (trigState_r)
            dcc_pkg::DCC_IDLE: begin
               if (anyTrig) begin
                  trigState_r <= dcc_pkg::DCC_ARMED;
               end
            end
            dcc_pkg::DCC_ARMED: begin
               if (!anyTrig) begin
                  trigState_r <= dcc_pkg::DCC_IDLE;
               end else if (trigEvt) begin
                  trigState_r <= dcc_pkg::DCC_RUN; // R18
               end
            end
            dcc_pkg::DCC_RUN: begin
               if (!anyTrig) begin
                  trigState_r <= dcc_pkg::DCC_IDLE;
               end else if (trigClear) begin
                  trigState_r <= dcc_pkg::DCC_ARMED; // R18
               end
            end
            default: begin
               trigState_r <= dcc_pkg::DCC_IDLE;
            end
         endcase
      end
   end

   //****************************************
   // outputs
   //****************************************
   always_ff @(posedge sys_clk) begin
      if (!porRst_n || !rst_n) begin
         ctr1_triggered_flag <= 1'b0;
      end else if (trigFire) begin
         ctr1_triggered_flag <= 1'b1; // R18
      end else if (trigClear) begin
         ctr1_triggered_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!porRst_n || !rst_n) begin
         ctr1_zero_evt <= 1'b0;
         ctr2_zero_evt <= 1'b0;
      end else begin
         ctr1_zero_evt <= z1 || z32; // R8 R20
         ctr2_zero_evt <= z2; // R20
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!porRst_n || !rst_n) begin
         data_value_match <= 2'b00;
      end else begin
         data_value_match <= {mIf.valueHit2, mIf.valueHit1}; // R12
      end
   end

   // mirrors the value that the counter takes at this edge
   always_ff @(posedge sys_clk) begin
      if (!porRst_n || !rst_n) begin
         debug_counter_value <= 32'h0000_0000;
      end else if (wrCnt) begin
         debug_counter_value <= wrSprCnt ? sprWrData : ctrLoadValue; // R9
      end else begin
         debug_counter_value <= count_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!porRst_n || !rst_n) begin
         sprRdData <= 32'h0000_0000;
      end else if (sprNum == `DCC_SPR_CTR_CTRL) begin
         sprRdData <= ctrlReg_r; // R19
      end else if (sprNum == `DCC_SPR_CMP_EXT) begin
         sprRdData <= extReg_r;
      end else if (sprNum == `DCC_SPR_CTR_VALUE) begin
         sprRdData <= count_r;
      end else begin
         sprRdData <= 32'h0000_0000;
      end
   end
endmodule

// [design/dcc_consts.svh]
// offsets, field positions, reset values and masks of the debug counter control block
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH
`define DCC_SPR_CTR_CTRL 10'h231
`define DCC_SPR_CMP_EXT 10'h234
`define DCC_SPR_CTR_VALUE 10'h230
`define DCC_CTR_CTRL_RESET 32'h0000_0000
`define DCC_CMP_EXT_RESET 32'h0000_0000
`define DCC_CMP_EXT_MASK 32'h00ff_000a
`define DCC_BIT_C2_FIRST 13
`define DCC_BIT_C2_EN_LO 19
`define DCC_BIT_C2_EN_HI 23
`define DCC_BIT_TRIG_LO 24
`define DCC_BIT_TRIG_HI 29
`define DCC_BIT_C2_TRIG 30
`define DCC_BIT_CONFIG 31
`define DCC_BIT_VC1_INV 1
`define DCC_BIT_VC2_INV 3
`define DCC_XM1_LO 16
`define DCC_XM2_LO 20
`define DCC_XM_MAX 4'hc
`define DCC_MODE_EXACT 2'h0
`define DCC_OWN_CTR_CTRL 0
`define DCC_OWN_CMP_EXT 1
`endif

// [design/dcc_pkg.sv]
// types of the debug counter control block
package dcc_pkg;
   typedef enum logic [1:0] {
      DCC_IDLE = 2'b00,
      DCC_ARMED = 2'b01,
      DCC_RUN = 2'b10
   } dcc_trig_state_t;
   typedef logic [3:0] dcc_mask_t;
endpackage

// [design/dcc_match_if.sv]
// carrier between control block and data compare helper
interface dcc_match_if;
   logic [31:0] addr;
   logic [31:0] cmp1Addr;
   logic [31:0] cmp2Addr;
   logic [3:0] mask1;
   logic [3:0] mask2;
   logic [1:0] pairMode;
   logic valueEq1;
   logic valueEq2;
   logic inv1;
   logic inv2;
   logic addrHit1;
   logic addrHit2;
   logic valueHit1;
   logic valueHit2;
   modport ctrl (output addr, cmp1Addr, cmp2Addr, mask1, mask2, pairMode, valueEq1,
      valueEq2, inv1, inv2, input addrHit1, addrHit2, valueHit1, valueHit2);
   modport cmp (input addr, cmp1Addr, cmp2Addr, mask1, mask2, pairMode, valueEq1,
      valueEq2, inv1, inv2, output addrHit1, addrHit2, valueHit1, valueHit2);
endinterface

// [design/dcc_data_cmp.sv]
// data compare helper: masked address compare and value compare polarity
`include "dcc_consts.svh"
module dcc_data_cmp (
   dcc_match_if.cmp m
);
   //****************************************
   // masked address compare
   //****************************************
   function automatic logic [31:0] low_mask(input dcc_pkg::dcc_mask_t xm);
      logic [31:0] mk;
      mk = 32'h0000_0000;
      if (xm <= `DCC_XM_MAX) begin // R13
         mk = (32'h0000_0001 << xm) - 32'h0000_0001;
      end
      return mk;
   endfunction

   logic exact;
   logic [31:0] mk1;
   logic [31:0] mk2;
   assign exact = (m.pairMode == `DCC_MODE_EXACT); // R15
   assign mk1 = exact ? low_mask(m.mask1) : 32'h0000_0000; // R13
   assign mk2 = exact ? low_mask(m.mask2) : 32'h0000_0000; // R14
   assign m.addrHit1 = ((m.addr ^ m.cmp1Addr) & ~mk1) == 32'h0000_0000;
   assign m.addrHit2 = ((m.addr ^ m.cmp2Addr) & ~mk2) == 32'h0000_0000;
   assign m.valueHit1 = m.valueEq1 ^ m.inv1; // R12
   assign m.valueHit2 = m.valueEq2 ^ m.inv2; // R12
endmodule

// [dv/dcc_evt_src.sv]
// event source model standing in for the core pipeline
module dcc_evt_src (
   input wire logic sys_clk,
   input wire logic [3:0] cmd,
   output logic ext_dbg_event1 = 1'b0,
   output logic ext_dbg_event2 = 1'b0,
   output logic instr_complete_evt = 1'b0,
   output logic [3:0] instr_addr_match = 4'h0,
   output logic dataAccess = 1'b0,
   output logic dataIsWrite = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   // ********
   // pulses
   // ********
   // 1,2 ext events, 3..5 instr cmp 1,3,4, 6 read, 7 write, 8 complete
   always @(posedge sys_clk) begin
      ext_dbg_event1 <= cmd == 4'h1;
      ext_dbg_event2 <= cmd == 4'h2;
      instr_complete_evt <= cmd == 4'h8;
      instr_addr_match <= {cmd == 4'h5, cmd == 4'h4, 1'b0, cmd == 4'h3};
      dataAccess <= cmd inside {4'h6, 4'h7};
      // direction keeps toggling while no access is made
      dataIsWrite <= cmd inside {4'h6, 4'h7} ? cmd == 4'h7 : !dataIsWrite;
   end
endmodule

// [dv/dcc_top_chk.sv]
// port assertions for the debug counter control block
`include "dcc_consts.svh"
module dcc_top_chk (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic porRst_n,
   input wire logic sprWrite,
   input wire logic [9:0] sprNum,
   input wire logic ctrLoad,
   input wire logic ext_dbg_event1,
   input wire logic ext_dbg_event2,
   input wire logic instr_complete_evt,
   input wire logic [3:0] instr_addr_match,
   input wire logic dataAccess,
   input wire logic trigClear,
   input wire logic [31:0] sprRdData,
   input wire logic [31:0] debug_counter_value,
   input wire logic ctr1_zero_evt,
   input wire logic ctr2_zero_evt,
   input wire logic ctr1_triggered_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   logic evAny;
   assign evAny = ext_dbg_event1 || ext_dbg_event2 || instr_complete_evt || (|instr_addr_match)
      || dataAccess || sprWrite || ctrLoad;
   // ********
   // checks
   // ********
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n || !porRst_n);
   a_rst_clears_state: assert property (disable iff (1'b0) !rst_n |=>
      debug_counter_value == 32'h0 && !ctr1_triggered_flag && !ctr1_zero_evt)
      else $error("state left after reset");
   a_por_clears_all: assert property (disable iff (1'b0) !porRst_n |=>
      sprRdData == 32'h0 && debug_counter_value == 32'h0)
      else $error("state left after power-on reset");
   a_zero_pulse_single: assert property (ctr1_zero_evt |=> !ctr1_zero_evt)
      else $error("zero pulse too long");
   a_zero_has_cause: assert property (ctr1_zero_evt || ctr2_zero_evt |-> $past(evAny))
      else $error("zero pulse without event");
   a_trig_has_cause: assert property ($rose(ctr1_triggered_flag) |-> $past(evAny) ||
      $past(evAny, 2))
      else $error("trigger without event");
   a_trig_clear_rearm: assert property (!evAny ##1 (trigClear && !evAny) |=>
      !ctr1_triggered_flag)
      else $error("trigger status not cleared");
   a_rd_unmapped_zero: assert property (!(sprNum inside {`DCC_SPR_CTR_CTRL,
      `DCC_SPR_CMP_EXT, `DCC_SPR_CTR_VALUE}) |=> sprRdData == 32'h0)
      else $error("unmapped read not zero");
   a_ext_reserved_zero: assert property (sprNum == `DCC_SPR_CMP_EXT |=>
      (sprRdData & ~`DCC_CMP_EXT_MASK) == 32'h0)
      else $error("reserved bits read set");
endmodule

bind dcc_top dcc_top_chk chk (.sys_clk, .rst_n, .porRst_n, .sprWrite, .sprNum, .ctrLoad,
   .ext_dbg_event1, .ext_dbg_event2, .instr_complete_evt, .instr_addr_match, .dataAccess,
   .trigClear, .sprRdData, .debug_counter_value, .ctr1_zero_evt, .ctr2_zero_evt,
   .ctr1_triggered_flag);

// [dv/test_debug_event_counter_ctrl.sv]
// self-checking bench of the debug counter control block
`include "dcc_consts.svh"
module test_debug_event_counter_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic porRst_n = 1'b0;
   logic ext_owner_flag = 1'b0;
   logic [1:0] resource_owner_select = 2'h0;
   logic sprWrite = 1'b0;
   logic [9:0] sprNum = 10'h0;
   logic [31:0] sprWrData = 32'h0;
   logic [12:0] ctr1EnLow = 13'h0;
   logic [31:0] dataAddr = 32'h0;
   logic [31:0] cmp1Addr = 32'h1000;
   logic [31:0] cmp2Addr = 32'h2000;
   logic [1:0] dataRdWrSelect1 = 2'h0;
   logic [1:0] dataRdWrSelect2 = 2'h0;
   logic valueEq1 = 1'b1;
   logic valueEq2 = 1'b0;
   logic trigClear = 1'b0;
   logic [3:0] cmd = 4'h0;
   logic [1:0] pairMode = 2'h0;
   logic dbgAllow = 1'b1;
   logic ext_dbg_event1, ext_dbg_event2, instr_complete_evt, dataAccess, dataIsWrite;
   logic [3:0] instr_addr_match;
   logic [31:0] sprRdData, debug_counter_value;
   logic ctr1_zero_evt, ctr2_zero_evt, ctr1_triggered_flag;
   logic [1:0] data_value_match;
   int n_errors = 0;
   int total_checks = 0;
   int nz1 = 0;
   int nz2 = 0;
   localparam logic [9:0] rCtl = `DCC_SPR_CTR_CTRL;
   localparam logic [9:0] rExt = `DCC_SPR_CMP_EXT;
   localparam logic [9:0] rCnt = `DCC_SPR_CTR_VALUE;
   logic [3:0] ec [5] = '{4'h5, 4'h6, 4'h7, 4'h6, 4'h7};
   logic [31:0] ea [5] = '{32'h0, 32'h1000, 32'h1000, 32'h2000, 32'h2000};
   logic [3:0] tc [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
   logic [3:0] mk [6] = '{4'h0, 4'h1, 4'h4, 4'h4, 4'hc, 4'hd};
   logic [15:0] ma [6] = '{16'h1001, 16'h1001, 16'h100f, 16'h1010, 16'h1fff, 16'h1001};
   logic me [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
   dcc_top uut (.sys_clk, .rst_n, .porRst_n, .ext_owner_flag, .resource_owner_select, .sprWrite,
      .sprNum, .sprWrData, .ctr1EnLow, .ctrLoadValue(32'h0), .ctrLoad(1'b0), .ext_dbg_event1,
      .ext_dbg_event2, .instr_complete_evt, .msr_dbg_allow(dbgAllow), .instr_addr_match,
      .dataAccess, .dataIsWrite, .dataRdWrSelect1, .dataRdWrSelect2, .dataAddr, .cmp1Addr,
      .cmp2Addr, .data_cmp_pair_mode(pairMode), .valueEq1, .valueEq2, .trigClear, .sprRdData,
      .debug_counter_value, .ctr1_zero_evt, .ctr2_zero_evt, .ctr1_triggered_flag,
      .data_value_match);
   dcc_evt_src evt (.sys_clk, .cmd, .ext_dbg_event1, .ext_dbg_event2, .instr_complete_evt,
      .instr_addr_match, .dataAccess, .dataIsWrite);
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      nz1 <= nz1 + (ctr1_zero_evt === 1'b1);
      nz2 <= nz2 + (ctr2_zero_evt === 1'b1);
   end
   // ********
   // tasks
   // ********
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [9:0] n, logic [31:0] d);
      sprWrite <= 1'b1;
      sprNum <= n;
      sprWrData <= d;
      @(posedge sys_clk);
      sprWrite <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(logic [9:0] n, logic [31:0] e);
      sprNum <= n;
      repeat (2) @(posedge sys_clk);
      chk("read data", e, sprRdData);
   endtask
   task automatic fire(logic [3:0] c);
      cmd <= c;
      @(posedge sys_clk);
      cmd <= 4'h0;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic clr;
      trigClear <= 1'b1;
      @(posedge sys_clk);
      trigClear <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rs(logic p);
      if (p) porRst_n <= 1'b0;
      else rst_n <= 1'b0;
      @(posedge sys_clk);
      rst_n <= 1'b1;
      porRst_n <= 1'b1;
      @(posedge sys_clk);
   endtask
   task automatic give_verdict;
      if (n_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ********
   // tests
   // ********
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      porRst_n <= 1'b1;
      @(posedge sys_clk);
      rd(rCtl, `DCC_CTR_CTRL_RESET);
      rd(rExt, `DCC_CMP_EXT_RESET);
      rd(10'h235, 32'h0);
      wr(rCtl, 32'hffff_ffff);
      rd(rCtl, 32'hffff_ffff);
      for (int i = 0; i < 2; i++) begin
         wr(rExt, i ? 32'h0 : 32'hffff_ffff);
         valueEq2 <= i[0];
         rd(rExt, i ? 32'h0 : `DCC_CMP_EXT_MASK);
         chk("value match", i ? 32'h3 : 32'h2, data_value_match);
      end
      wr(rCtl, 32'h8000_0000);
      wr(rExt, 32'h0001_0000);
      ext_owner_flag <= 1'b1;
      resource_owner_select <= 2'h2;
      rs(1'b0);
      rd(rCtl, 32'h8000_0000);
      rd(rExt, 32'h0);
      wr(rExt, 32'h0001_0000);
      ext_owner_flag <= 1'b0;
      resource_owner_select <= 2'h1;
      rs(1'b0);
      rd(rCtl, 32'h0);
      rd(rExt, 32'h0);
      wr(rExt, 32'h0001_0000);
      ext_owner_flag <= 1'b1;
      resource_owner_select <= 2'h0;
      rs(1'b1);
      rd(rExt, 32'h0);
      ext_owner_flag <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         wr(rCtl, 32'h1 << (19 + i));
         wr(rCnt, 32'h0005_0005);
         for (int j = 0; j < 5; j++) begin
            dataAddr <= ea[j];
            fire(ec[j]);
         end
         chk("counter", 32'h0004_0005, debug_counter_value);
      end
      wr(rCtl, 32'h0008_0000);
      wr(rCnt, 32'h0002_0007);
      fire(4'h5);
      fire(4'h5);
      chk("counter", 32'h0000_0007, debug_counter_value);
      chk("zero two", 32'h1, nz2);
      dataRdWrSelect1 <= 2'h1;
      dataRdWrSelect2 <= 2'h1;
      wr(rCtl, 32'h0030_0000);
      wr(rCnt, 32'h0005_0000);
      dataAddr <= 32'h1000;
      fire(4'h6);
      fire(4'h7);
      chk("counter", 32'h0004_0000, debug_counter_value);
      dataRdWrSelect1 <= 2'h0;
      ctr1EnLow <= 13'h4;
      wr(rCnt, 32'h0000_0003);
      dbgAllow <= 1'b0;
      fire(4'h8);
      dbgAllow <= 1'b1;
      fire(4'h8);
      chk("counter", 32'h0000_0002, debug_counter_value);
      ctr1EnLow <= 13'h1;
      wr(rCtl, 32'h0000_2000);
      wr(rCnt, 32'h0003_0003);
      fire(4'h1);
      chk("counter", 32'h0002_0002, debug_counter_value);
      wr(rCtl, 32'h8000_2000);
      wr(rCnt, 32'h0001_0000);
      fire(4'h1);
      chk("counter", 32'h0000_ffff, debug_counter_value);
      wr(rCtl, 32'h0);
      wr(rCnt, 32'h0000_0001);
      cmd <= 4'h1;
      @(posedge sys_clk);
      cmd <= 4'h0;
      wr(rCnt, 32'h0000_0005);
      repeat (2) @(posedge sys_clk);
      chk("counter", 32'h0000_0005, debug_counter_value);
      chk("zero one", 32'h1, nz1);
      wr(rCtl, 32'h0008_0000);
      wr(rCnt, 32'h0001_0000);
      cmd <= 4'h5;
      @(posedge sys_clk);
      cmd <= 4'h0;
      wr(rCtl, 32'h0);
      repeat (2) @(posedge sys_clk);
      chk("zero two", 32'h2, nz2);
      rd(rCtl, 32'h0);
      ctr1EnLow <= 13'h0;
      for (int i = 0; i < 6; i++) begin
         wr(rCtl, 32'h1 << (24 + i));
         fire(tc[(i + 1) % 6]);
         chk("trigger", 32'h0, ctr1_triggered_flag);
         fire(tc[i]);
         chk("trigger", 32'h1, ctr1_triggered_flag);
         clr();
         chk("trigger", 32'h0, ctr1_triggered_flag);
      end
      ctr1EnLow <= 13'h1;
      wr(rCtl, 32'h4008_0000);
      wr(rCnt, 32'h0001_0005);
      fire(4'h1);
      chk("counter", 32'h0001_0005, debug_counter_value);
      fire(4'h5);
      chk("trigger", 32'h1, ctr1_triggered_flag);
      fire(4'h1);
      chk("counter", 32'h0000_0004, debug_counter_value);
      clr();
      ctr1EnLow <= 13'h0;
      wr(rCtl, 32'h1000_0000);
      for (int i = 0; i < 6; i++) begin
         wr(rExt, {12'h0, mk[i], 16'h0});
         dataAddr <= {16'h0, ma[i]};
         fire(4'h6);
         chk("mask hit", {31'h0, me[i]}, ctr1_triggered_flag);
         clr();
      end
      pairMode <= 2'h1;
      wr(rExt, 32'h0004_0000);
      dataAddr <= 32'h100f;
      fire(4'h6);
      chk("mode mask", 32'h0, ctr1_triggered_flag);
      pairMode <= 2'h0;
      wr(rExt, 32'h0040_0000);
      wr(rCtl, 32'h0040_0000);
      wr(rCnt, 32'h0001_0000);
      dataAddr <= 32'h200f;
      fire(4'h6);
      chk("counter", 32'h0, debug_counter_value);
      give_verdict();
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_errors++;
      give_verdict();
   end
endmodule
